// ---- pkg/crc_defines.svh ----
// constants of the clock ratio control block
// Operation
// R1: control register is 16 bits, word accesses only.
// R2: external power-on reset restores fields; watchdog overflow reset keeps them.
// R3: reserved bits read zero; software writes zero there.
// R4: keep bit resets to one; cleared holds bus clock pin low in standby.
// R5: keep set and mode 1 or 5: external clock drives bus pin in standby.
// R6: entering standby with keep set, bus pin low two peripheral cycles.
// R7: multiplier field resets to 000; 000 is x1, 001 is x2.
// R8: divider field resets to 011; 000 /1, 001 /2, 011 /4.
// R9: peripheral clock divides the first PLL output, not the input.
// R10: processor clock rate changes only via the multiplier.
// R11: peripheral rate changes via multiplier or divider, both software set.
// R12: multiplier change stops clocks until watchdog overflow, then resumes.
// R13: divider-only change applies at once, no watchdog pause.
// R14: with mode-change arm set, writes apply only after standby exit.
// R15: modes 1,5 take external clock; 2,6 crystal; 1,2 x4, 5,6 x2. Code applies no x4 or x2 factor.
// R16: reset value 0x1003; writes to reserved bits are dropped.
// R17: new ratios take effect only on a clean clock boundary.
`ifndef CRC_DEFINES_SVH
`define CRC_DEFINES_SVH

`define CRC_CTRL_OFF    12'h000
`define CRC_STAT_OFF    12'h004
`define CRC_RESET_VAL   16'h1003
`define CRC_WR_MASK     16'h1707
`define CRC_KEEP_BIT    12
`define CRC_MULT_MSB    10
`define CRC_MULT_LSB    8
`define CRC_DIV_MSB     2
`define CRC_DIV_LSB     0
`define CRC_MULT_X1     3'h0
`define CRC_MULT_X2     3'h1
`define CRC_DIV_1       3'h0
`define CRC_DIV_2       3'h1
`define CRC_DIV_4       3'h3
`define CRC_MODE_EXT_X4 3'h1
`define CRC_MODE_XTL_X4 3'h2
`define CRC_MODE_EXT_X2 3'h5
`define CRC_MODE_XTL_X2 3'h6
`define CRC_PH_LAST     3'h7
`define CRC_PH_HALF     3'h3
`define CRC_GAP_TICKS   2'h2

`endif

// ---- pkg/crc_pkg.sv ----
// types of the clock ratio control block
package crc_pkg;
   typedef enum logic [3:0]
   {
      CRC_RUN  = 4'b0001,
      CRC_LOCK = 4'b0010,
      CRC_GAP  = 4'b0100,
      CRC_STBY = 4'b1000
   } crc_state_t;
endpackage

// ---- test/clock_ratio_control_register_tb.sv ----
// self-checking bench of the clock ratio control register
`timescale 1ns/100ps
`include "crc_defines.svh"
module clock_ratio_control_register_tb
   import crc_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0]  pstrb = 0;
   logic        pready, pslverr, er, bus_pin, cpu_en, per_en, wdt_run;
   logic        wdt_reset = 0, wdt_overflow = 0, arm = 0, stby = 0, ext = 0;
   logic [2:0]  mode = 3'h1;
   int          err_count = 0, checks_done = 0, nc, np;

   always #4 pclk = ~pclk;

   crc_clock_ratio dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wdt_reset(wdt_reset), .wdt_overflow(wdt_overflow),
      .mode_change_arm(arm), .standby_req(stby), .clock_mode(mode),
      .external_clock_in_pin(ext), .bus_clock_out_pin(bus_pin),
      .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .wdt_run(wdt_run)
   );

   ////////////////////////////////////////////////////////////////////
   task conclude;
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // master holds the request until pready is seen high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_count++;
         conclude;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // status polling, bounded
   task wait_st(input logic [3:0] st);
      int n;
      n = 0;
      do
      begin
         apb(0, `CRC_STAT_OFF, 0, 4'hf);
         n++;
      end
      while (rd[11:8] !== st && n < 80);
      if (n >= 80)
      begin
         err_count++;
         conclude;
      end
   endtask

   task count_en(input int cyc);
      nc = 0;
      np = 0;
      repeat (cyc)
      begin
         @(posedge pclk);
         nc += (cpu_en === 1'b1);
         np += (per_en === 1'b1);
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   task t_reset_values;
      apb(0, `CRC_CTRL_OFF, 0, 4'hf);
      check("ctrl reset", rd, 32'h0000_1003);
      apb(0, `CRC_STAT_OFF, 0, 4'hf);
      check("div reset", rd[2:0], `CRC_DIV_4);
      check("mult reset", rd[6:4], `CRC_MULT_X1);
      count_en(64);
      check("x1 cpu ticks", nc, 8);
      check("div4 periph ticks", np, 2);
   endtask

   task t_access_rules;
      arm <= 1;
      // ones in every reserved bit, writable fields at their reset codes
      apb(1, `CRC_CTRL_OFF, 32'hffff_f8fb, 4'hf);
      apb(0, `CRC_CTRL_OFF, 0, 4'hf);
      check("reserved dropped", rd, 32'h0000_1003);
      apb(1, `CRC_CTRL_OFF, 32'h0000_0000, 4'h1);
      check("byte write err", er, 1);
      apb(0, `CRC_CTRL_OFF, 0, 4'hf);
      check("byte write ignored", rd, 32'h0000_1003);
      apb(0, 12'h008, 0, 4'hf);
      check("unmapped err", er, 1);
      arm <= 0;
   endtask

   task t_div_change;
      apb(1, `CRC_CTRL_OFF, 32'h0000_1001, 4'hf);
      repeat (10) @(posedge pclk);
      check("no lock on div", wdt_run, 0);
      count_en(64);
      check("div2 cpu", nc, 8);
      check("div2 periph", np, 4);
   endtask

   task t_mult_change;
      int n;
      apb(1, `CRC_CTRL_OFF, 32'h0000_1101, 4'hf);
      n = 0;
      while (wdt_run !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      check("lock entered", wdt_run, 1);
      count_en(24);
      check("cpu stopped", nc + np, 0);
      wdt_overflow <= 1;
      @(posedge pclk);
      wdt_overflow <= 0;
      repeat (12) @(posedge pclk);
      check("lock left", wdt_run, 0);
      count_en(64);
      check("x2 cpu", nc, 16);
      check("x2 div2 periph", np, 8);
      wdt_reset <= 1;
      @(posedge pclk);
      wdt_reset <= 0;
      apb(0, `CRC_CTRL_OFF, 0, 4'hf);
      check("kept on wdt reset", rd, 32'h0000_1101);
   endtask

   // arm-held write, standby with keep set, external clock passthrough
   task t_standby_keep;
      arm <= 1;
      apb(1, `CRC_CTRL_OFF, 32'h0000_1100, 4'hf);
      apb(0, `CRC_STAT_OFF, 0, 4'hf);
      check("armed div held", rd[2:0], `CRC_DIV_2);
      ext <= 1;
      stby <= 1;
      wait_st(CRC_GAP);
      check("gap pin low", bus_pin, 0);
      wait_st(CRC_STBY);
      repeat (5) @(posedge pclk);
      check("pin follows ext hi", bus_pin, 1);
      ext <= 0;
      repeat (5) @(posedge pclk);
      check("pin follows ext lo", bus_pin, 0);
      mode <= 3'h2;
      ext <= 1;
      repeat (5) @(posedge pclk);
      check("crystal mode pin", bus_pin, 0);
      mode <= 3'h5;
      repeat (5) @(posedge pclk);
      check("mode5 pin follows ext", bus_pin, 1);
      stby <= 0;
      wait_st(CRC_RUN);
      check("armed div applied", rd[2:0], `CRC_DIV_1);
      arm <= 0;
   endtask

   task t_standby_nokeep;
      apb(1, `CRC_CTRL_OFF, 32'h0000_0100, 4'hf);
      stby <= 1;
      wait_st(CRC_STBY);
      repeat (5) @(posedge pclk);
      check("nokeep pin low", bus_pin, 0);
      stby <= 0;
      wait_st(CRC_RUN);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_reset_values;
      t_access_rules;
      t_div_change;
      t_mult_change;
      t_standby_keep;
      t_standby_nokeep;
      conclude;
   end
endmodule

// ---- verilog/crc_clk_div.sv ----
// selectable divider of a tick stream by 1, 2 or 4
`timescale 1ns/100ps
`include "crc_defines.svh"
module crc_clk_div
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick_in,
   input  wire logic [2:0] ratio,
   output logic            tick_out
);
   logic [1:0] cnt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt <= 2'h0;
      else if (tick_in)
         cnt <= cnt + 2'h1;
   end

   // output held in a flop so the consumer sees a clean one-cycle enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_out <= 1'b0;
      else
         tick_out <= tick_in && ((ratio == `CRC_DIV_1) ||
                                 (ratio == `CRC_DIV_2 && cnt[0]) ||
                                 (ratio == `CRC_DIV_4 && cnt == 2'h3));
   end
endmodule

// ---- verilog/crc_clock_ratio.sv ----
// clock ratio control register with clock enable generation
`timescale 1ns/100ps
`include "crc_defines.svh"
module crc_clock_ratio
   import crc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wdt_reset,
   input  wire logic        wdt_overflow,
   input  wire logic        mode_change_arm,
   input  wire logic        standby_req,
   input  wire logic [2:0]  clock_mode,
   input  wire logic        external_clock_in_pin,
   output logic             bus_clock_out_pin,
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic             wdt_run
);
   logic [15:0] clock_ratio_control;
   logic [2:0]  act_mult;
   logic [2:0]  act_div;
   logic [2:0]  ph;
   logic        apply_pend;
   logic [1:0]  gap_cnt;
   logic        ext_meta;
   logic        ext_sync;
   logic        pll1_tick;
   logic        div_feed;
   crc_state_t  state;
   crc_state_t  next_state;

   wire         acc      = psel && penable && pready;
   wire         hit_ctrl = (paddr == `CRC_CTRL_OFF);
   wire         hit_stat = (paddr == `CRC_STAT_OFF);
   wire         word_ok  = (pstrb[1:0] == 2'h3);
   wire         wr_ctrl  = acc && pwrite && hit_ctrl && word_ok;
   wire         bound    = (ph == `CRC_PH_LAST);
   wire         keep     = clock_ratio_control[`CRC_KEEP_BIT];
   wire [2:0]   reg_mult = clock_ratio_control[`CRC_MULT_MSB:`CRC_MULT_LSB];
   wire [2:0]   reg_div  = clock_ratio_control[`CRC_DIV_MSB:`CRC_DIV_LSB];
   wire         ext_mode = (clock_mode == `CRC_MODE_EXT_X4) ||
                           (clock_mode == `CRC_MODE_EXT_X2);

   ////////////////////////////////////////////////////////////////////////
   // apb slave

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= psel && !penable && !pready;
   end

   // writes that do not strobe both low byte lanes (pstrb[1:0]) are refused with an error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else if (psel && !penable && !pready)
         pslverr <= !(hit_ctrl || hit_stat) || (pwrite && !word_ok); // R1
      else
         pslverr <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pready && !pwrite && hit_ctrl)
         prdata <= {16'h0000, clock_ratio_control};
      else if (psel && !penable && !pready && !pwrite && hit_stat)
         prdata <= {16'h0000, ext_sync, apply_pend, 2'h0, state,
                    1'b0, act_mult, 1'b0, act_div};
      else
         prdata <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // control register; only the external reset restores it, to 0x1003

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clock_ratio_control <= `CRC_RESET_VAL; // R2 R4 R7 R8 R16
      else if (wr_ctrl)
         clock_ratio_control <= pwdata[15:0] & `CRC_WR_MASK; // R1 R3 R16
   end

   // a write while armed waits for the standby exit instead
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         apply_pend <= 1'b0;
      else if (wr_ctrl && !mode_change_arm)
         apply_pend <= 1'b1;
      else if (state == CRC_RUN && bound)
         apply_pend <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // external clock input synchroniser

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
      end
      else
      begin
         ext_meta <= external_clock_in_pin;
         ext_sync <= ext_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus clock phase; eight pclk cycles per bus clock

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ph <= 3'h0;
      else
         ph <= ph + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer

   always_comb
   begin
      next_state = state;
      case (state)
         CRC_RUN:
            if (bound && apply_pend && reg_mult != act_mult)
               next_state = CRC_LOCK; // R12
            else if (bound && standby_req)
               next_state = keep ? CRC_GAP : CRC_STBY; // R4 R6
         CRC_LOCK:
            if (wdt_overflow)
               next_state = CRC_RUN; // R12
         CRC_GAP:
            if (gap_cnt == `CRC_GAP_TICKS)
               next_state = CRC_STBY; // R6
         CRC_STBY:
            if (!standby_req && bound)
               next_state = CRC_RUN;
         default:
            next_state = CRC_RUN;
      endcase
   end

   // watchdog reset restarts the sequencer but leaves the register alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= CRC_RUN;
      else if (wdt_reset)
         state <= CRC_RUN; // R2
      else
         state <= next_state;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_cnt <= 2'h0;
      else if (state != CRC_GAP)
         gap_cnt <= 2'h0;
      else if (periph_clk_en)
         gap_cnt <= gap_cnt + 2'h1; // R6
   end

   ////////////////////////////////////////////////////////////////////////
   // active ratios, changed on a bus clock boundary except at relock end and on watchdog reset

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         act_mult <= `CRC_MULT_X1;
      else if (wdt_reset)
         act_mult <= reg_mult;
      else if (state == CRC_LOCK && wdt_overflow)
         act_mult <= reg_mult; // R10 R12
      else if (state == CRC_STBY && next_state == CRC_RUN)
         act_mult <= reg_mult; // R14
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         act_div <= `CRC_DIV_4;
      else if (wdt_reset)
         act_div <= reg_div;
      else if (state == CRC_RUN && bound && apply_pend && reg_mult == act_mult)
         act_div <= reg_div; // R11 R13 R17
      else if (state == CRC_LOCK && wdt_overflow)
         act_div <= reg_div; // R11
      else if (state == CRC_STBY && next_state == CRC_RUN)
         act_div <= reg_div; // R14
   end

   ////////////////////////////////////////////////////////////////////////
   // clock enables

   // x1 ticks once per bus period, x2 twice
   assign pll1_tick = bound || (act_mult == `CRC_MULT_X2 && ph == `CRC_PH_HALF); // R10
   assign div_feed  = pll1_tick && (state == CRC_RUN || state == CRC_GAP);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cpu_clk_en <= 1'b0;
      else
         cpu_clk_en <= div_feed; // R10 R12
   end

   crc_clk_div u_div
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick_in  (div_feed),
      .ratio    (act_div),
      .tick_out (periph_clk_en)
   ); // R9

   // watchdog counts only while the clocks are held for relock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wdt_run <= 1'b0;
      else
         wdt_run <= (next_state == CRC_LOCK) && !wdt_reset; // R12
   end

   // crystal modes have no bypass path, so the pin rests low there
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bus_clock_out_pin <= 1'b0;
      else if (state == CRC_GAP)
         bus_clock_out_pin <= 1'b0; // R6
      else if (state == CRC_STBY)
         bus_clock_out_pin <= keep && ext_mode && ext_sync; // R4 R5 R15
      else
         bus_clock_out_pin <= !ph[2];
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_word_only : assert property (@(posedge pclk) disable iff (!presetn) // R1
      (acc && pwrite && hit_ctrl && !word_ok) |=> $stable(clock_ratio_control))
      else $error("partial write changed the register");

   a_rsvd_zero : assert property (@(posedge pclk) disable iff (!presetn) // R3
      (clock_ratio_control & ~`CRC_WR_MASK) == 16'h0000)
      else $error("reserved bit set");

   a_keep_low : assert property (@(posedge pclk) disable iff (!presetn) // R4
      (state == CRC_STBY && !keep) |=> !bus_clock_out_pin)
      else $error("bus clock not low in standby");

   a_ext_pass : assert property (@(posedge pclk) disable iff (!presetn) // R5
      (state == CRC_STBY && keep && ext_mode) |=> bus_clock_out_pin == $past(ext_sync))
      else $error("external clock not passed through");

   a_gap_low : assert property (@(posedge pclk) disable iff (!presetn) // R6
      (state == CRC_RUN && next_state == CRC_GAP && !wdt_reset)
      |=> (state == CRC_GAP) [*2] ##0 !bus_clock_out_pin)
      else $error("standby gap too short");

   a_lock_stop : assert property (@(posedge pclk) disable iff (!presetn) // R12
      (state == CRC_LOCK) ##1 (state == CRC_LOCK) |-> !cpu_clk_en && wdt_run)
      else $error("clock ran during relock");

   a_arm_hold : assert property (@(posedge pclk) disable iff (!presetn) // R14
      (wr_ctrl && mode_change_arm && !apply_pend && state == CRC_RUN && !wdt_reset)
      |=> $stable(act_mult) && $stable(act_div))
      else $error("armed write changed the clock");

   a_div_bound : assert property (@(posedge pclk) disable iff (!presetn) // R17
      (!$stable(act_div) && $past(state) == CRC_RUN && !$past(wdt_reset))
      |-> $past(ph) == `CRC_PH_LAST)
      else $error("divider changed off boundary");

   a_cpu_rate : assert property (@(posedge pclk) disable iff (!presetn) // R10
      (cpu_clk_en && act_mult == `CRC_MULT_X1 && $stable(act_mult))
      |-> $past(ph) == `CRC_PH_LAST)
      else $error("x1 processor tick off phase");
endmodule
